/* rtl/prc_pkg.sv */
// Constants, register map and code-group table for the PHY receive coding block
package prc_pkg;
  // Clock and timing
  localparam int CLK_NS = 50;
  localparam int TX_HALF_NS = 50;
  localparam int TX_HALF_INT = (TX_HALF_NS / CLK_NS < 1) ? 1 : TX_HALF_NS / CLK_NS;
  localparam logic [3:0] TX_HALF_CYC = 4'(TX_HALF_INT);
  localparam int FLP_GAP_NS = 16000;
  localparam logic [11:0] FLP_GAP_CYC = 12'(FLP_GAP_NS / CLK_NS);
  localparam int IDLE_NS = 3000000;
  localparam int IDLE_CYC = IDLE_NS / CLK_NS;
  localparam logic [4:0] LOCK_RUN = 5'h1C;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ADV = 8'h08;
  localparam logic [7:0] REG_LPA = 8'h0C;
  localparam logic [7:0] REG_VEND = 8'h40;
  // Field positions and reset values
  localparam int CTRL_FDX = 8;
  localparam int CTRL_PDOWN = 11;
  localparam int CTRL_ANEN = 12;
  localparam int CTRL_SPD = 13;
  localparam int VEND_APR = 4;
  localparam logic [15:0] CTRL_RST = 16'h3000;
  localparam logic [15:0] VEND_RST = 16'h0010;
  localparam logic [3:0] ADV_RST = 4'hF;
  // Ability bits
  localparam int ABL_10HD = 0;
  localparam int ABL_10FD = 1;
  localparam int ABL_100HD = 2;
  localparam int ABL_100FD = 3;
  // Code groups
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [3:0] PRE_NIB = 4'h5;
  typedef enum logic [1:0] {RX_HUNT, RX_DATA, RX_WAIT_R} prc_rx_state_type;
  // 5B to 4B lookup, bit 4 of result flags a bad group
  function automatic logic [4:0] prc_dec(input logic [4:0] c);
    case (c)
      5'h1E: prc_dec = 5'h00;
      5'h09: prc_dec = 5'h01;
      5'h14: prc_dec = 5'h02;
      5'h15: prc_dec = 5'h03;
      5'h0A: prc_dec = 5'h04;
      5'h0B: prc_dec = 5'h05;
      5'h0E: prc_dec = 5'h06;
      5'h0F: prc_dec = 5'h07;
      5'h12: prc_dec = 5'h08;
      5'h13: prc_dec = 5'h09;
      5'h16: prc_dec = 5'h0A;
      5'h17: prc_dec = 5'h0B;
      5'h1A: prc_dec = 5'h0C;
      5'h1B: prc_dec = 5'h0D;
      5'h1C: prc_dec = 5'h0E;
      5'h1D: prc_dec = 5'h0F;
      default: prc_dec = 5'h10;
    endcase
  endfunction
  // Priority pick: {ok, speed100, full duplex}
  function automatic logic [2:0] prc_pick(input logic [3:0] a);
    if (a[ABL_100FD]) prc_pick = 3'h7;
    else if (a[ABL_100HD]) prc_pick = 3'h6;
    else if (a[ABL_10FD]) prc_pick = 3'h5;
    else if (a[ABL_10HD]) prc_pick = 3'h4;
    else prc_pick = 3'h0;
  endfunction
endpackage

/* rtl/prc_phy_rx.sv */
// PHY receive coding, 10M Manchester, CRS/COL, negotiation and power control
//
// Notes on behaviour
// - 100M path turns serial line bits into MII nibbles.
// - Line clock is recovered outside; its edges sample line data.
// - NRZI line bits are decoded to NRZ by XOR with previous bit.
// - Descrambler undoes scrambling and feeds the unaligned alignment window.
// - Alignment starts on J/K; later groups use that fixed boundary.
// - Each aligned 5-bit group maps to a nibble by table lookup.
// - J/K pair is dropped and two preamble nibbles are emitted.
// - T/R end pair is dropped, never forwarded as nibbles.
// - 10M transmit nibbles are Manchester coded; received Manchester becomes nibbles.
// - Half duplex flags COL when transmit and receive overlap.
// - Full duplex never flags COL.
// - Half duplex CRS follows transmit or receive.
// - Full duplex CRS follows receive only.
// - Advertise abilities, acknowledge common ones, resolve by fixed priority.
// - Without partner negotiation, detect line signal and pick matching mode.
// - No media signal drops the device into reduced power.
// - Reduced power still emits fast link pulses.
// - Any valid media signal wakes the device.
// - Clearing vendor register bit 4 disables automatic power reduction.
// - Control bit 11 powers down all but the management registers.
// - Start delimiter is J=11000 then K=10001.
// - End delimiter is T=01101 then R=00111.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module prc_phy_rx #(
  parameter int IDLE_CYC = prc_pkg::IDLE_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Line side, asynchronous
  input wire logic line_clk,
  input wire logic line_dat,
  input wire logic sig_detect,
  input wire logic sig_flp,
  input wire logic sig_nlp,
  input wire logic sig_mlt3,
  // Partner ability word from page receiver
  input wire logic lp_word_stb,
  input wire logic [3:0] lp_word,
  // MII transmit
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic tx_nib_req,
  // MII receive and status
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic rx_nib_stb,
  output logic crs,
  output logic col,
  // Line transmit and link
  output logic man_tx,
  output logic flp_out,
  output logic [3:0] adv_word,
  output logic adv_ack,
  output logic pwr_low,
  output logic link_up
);
  ////////////////////////////////////////////////////////////////////////
  logic [5:0] s1_q, s2_q, s3_q, lvl_q, lvl_n;
  logic lrise, lfall, dat;
  logic [15:0] ctrl_q, vend_q;
  logic [3:0] adv_q, lp_q;
  logic lp_vld_q, spd_q, fdx_q, link_q, pwr_red_q;
  logic acc_q, awr_q;
  logic [7:0] aidx_q;
  logic [31:0] rd_mux;
  logic pdown, en, sig_any;
  logic [15:0] idle_q;
  logic [11:0] flp_q;
  logic prev_q, nrz, key, plain, locked_q;
  logic [10:0] lfsr_q;
  logic [4:0] run_q;
  logic [9:0] win_q, win_n;
  logic [2:0] bcnt_q;
  logic pre2_q;
  prc_pkg::prc_rx_state_type st_q;
  logic go100, jk_hit, grp_tick, pre2_tick;
  logic [4:0] grp, dec;
  logic h1_q, herr_q;
  logic [3:0] nib10_q;
  logic [1:0] cnt10_q;
  logic ev10;
  logic busy_q, ph_q;
  logic [3:0] sh_q, hcnt_q;
  logic [1:0] bit_q;

  ////////////////////////////////////////////////////////////////////////
  // Three-stage sync; a change counts once stages two and three agree
  assign lvl_n = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  assign lrise = lvl_n[0] & ~lvl_q[0];
  assign lfall = ~lvl_n[0] & lvl_q[0];
  assign dat = lvl_n[1];
  assign sig_any = |lvl_n[5:2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      lvl_q <= 6'h00;
    end
    else
    begin
      s1_q <= {sig_mlt3, sig_nlp, sig_flp, sig_detect, line_dat, line_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state so reads see writes just made
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_q <= 1'b0;
      awr_q <= 1'b0;
      aidx_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      acc_q <= hsel & htrans[1] & hready;
      if (hsel & htrans[1] & hready)
      begin
        awr_q <= hwrite;
        aidx_q <= haddr[7:0];
        hreadyout <= 1'b0;
      end
      else if (acc_q)
        hreadyout <= 1'b1;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (aidx_q)
      prc_pkg::REG_CTRL: rd_mux = {16'h0000, ctrl_q};
      prc_pkg::REG_STAT: rd_mux = {24'h00_0000, st_q != prc_pkg::RX_HUNT, locked_q,
        pwr_red_q, lp_vld_q, fdx_q, spd_q, link_q, pdown};
      prc_pkg::REG_ADV: rd_mux = {28'h000_0000, adv_q};
      prc_pkg::REG_LPA: rd_mux = {28'h000_0000, lp_q};
      prc_pkg::REG_VEND: rd_mux = {16'h0000, vend_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Register writes in the data phase; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= prc_pkg::CTRL_RST;
      vend_q <= prc_pkg::VEND_RST;
      adv_q <= prc_pkg::ADV_RST;
      hrdata <= 32'h0000_0000;
    end
    else if (acc_q)
    begin
      if (!awr_q)
        hrdata <= rd_mux;
      else if (aidx_q == prc_pkg::REG_CTRL)
        ctrl_q <= hwdata[15:0];
      else if (aidx_q == prc_pkg::REG_ADV)
        adv_q <= hwdata[3:0];
      else if (aidx_q == prc_pkg::REG_VEND)
        vend_q <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power control; management stays alive in power-down
  assign pdown = ctrl_q[prc_pkg::CTRL_PDOWN];
  assign en = ~pdown & ~pwr_red_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idle_q <= 16'h0000;
      pwr_red_q <= 1'b0;
    end
    else if (sig_any | ~vend_q[prc_pkg::VEND_APR])
    begin
      idle_q <= 16'h0000;
      pwr_red_q <= 1'b0;
    end
    else if (idle_q == 16'(IDLE_CYC - 1))
      pwr_red_q <= 1'b1;
    else
      idle_q <= idle_q + 16'h0001;
  end

  // Link pulses keep going while unlinked outside power-down, also at low power
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flp_q <= 12'h000;
      flp_out <= 1'b0;
      pwr_low <= 1'b0;
    end
    else
    begin
      flp_out <= 1'b0;
      pwr_low <= pwr_red_q;
      if (pdown | link_q | flp_q == prc_pkg::FLP_GAP_CYC - 12'h001)
        flp_q <= 12'h000;
      else
        flp_q <= flp_q + 12'h001;
      if (~pdown & ~link_q & flp_q == prc_pkg::FLP_GAP_CYC - 12'h001)
        flp_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Negotiation, parallel detection and forced mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lp_q <= 4'h0;
      lp_vld_q <= 1'b0;
      link_q <= 1'b0;
      spd_q <= 1'b0;
      fdx_q <= 1'b0;
      adv_word <= 4'h0;
      adv_ack <= 1'b0;
      link_up <= 1'b0;
    end
    else
    begin
      adv_word <= adv_q;
      adv_ack <= lp_vld_q & |(adv_q & lp_q);
      link_up <= link_q;
      if (~en | ~ctrl_q[prc_pkg::CTRL_ANEN])
        lp_vld_q <= 1'b0;
      else if (lp_word_stb)
      begin
        lp_q <= lp_word;
        lp_vld_q <= 1'b1;
      end
      if (~en)
        link_q <= 1'b0;
      else if (~ctrl_q[prc_pkg::CTRL_ANEN])
      begin
        link_q <= sig_any;
        spd_q <= ctrl_q[prc_pkg::CTRL_SPD];
        fdx_q <= ctrl_q[prc_pkg::CTRL_FDX];
      end
      else if (lp_vld_q)
        {link_q, spd_q, fdx_q} <= prc_pkg::prc_pick(adv_q & lp_q);
      else if (lvl_n[5] & adv_q[prc_pkg::ABL_100HD])
        {link_q, spd_q, fdx_q} <= 3'h6;
      else if (lvl_n[4] & adv_q[prc_pkg::ABL_10HD])
        {link_q, spd_q, fdx_q} <= 3'h4;
      else
        link_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // NRZI decode and self-synchronising descrambler, x^11 + x^9 + 1
  assign go100 = en & spd_q & lrise;
  assign nrz = dat ^ prev_q;
  assign key = lfsr_q[10] ^ lfsr_q[8];
  assign plain = nrz ^ key;
  assign win_n = {win_q[8:0], plain};

  // Idle is all ones, so unlocked the key is the inverted line bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_q <= 1'b0;
      lfsr_q <= 11'h000;
      run_q <= 5'h00;
      locked_q <= 1'b0;
      win_q <= 10'h000;
    end
    else if (~en | ~spd_q)
    begin
      locked_q <= 1'b0;
      run_q <= 5'h00;
    end
    else if (lrise)
    begin
      prev_q <= dat;
      lfsr_q <= {lfsr_q[9:0], locked_q ? key : ~nrz};
      run_q <= plain ? ((run_q == prc_pkg::LOCK_RUN) ? run_q : run_q + 5'h01) : 5'h00;
      if (run_q == prc_pkg::LOCK_RUN)
        locked_q <= 1'b1;
      if (locked_q)
        win_q <= win_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alignment events, MSB of each group first on the line
  assign jk_hit = go100 & locked_q & st_q == prc_pkg::RX_HUNT
    & win_n == {prc_pkg::CG_J, prc_pkg::CG_K};
  assign grp_tick = go100 & locked_q & st_q != prc_pkg::RX_HUNT & bcnt_q == 3'h4;
  assign pre2_tick = go100 & locked_q & pre2_q & bcnt_q == 3'h1;
  assign grp = win_n[4:0];
  assign dec = prc_pkg::prc_dec(grp);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= prc_pkg::RX_HUNT;
      bcnt_q <= 3'h0;
      pre2_q <= 1'b0;
    end
    else if (~en | ~spd_q | ~locked_q)
    begin
      st_q <= prc_pkg::RX_HUNT;
      pre2_q <= 1'b0;
    end
    else if (go100)
    begin
      bcnt_q <= (bcnt_q == 3'h4 | jk_hit) ? 3'h0 : bcnt_q + 3'h1;
      if (pre2_tick)
        pre2_q <= 1'b0;
      case (st_q)
        prc_pkg::RX_HUNT:
          if (jk_hit)
          begin
            st_q <= prc_pkg::RX_DATA;
            pre2_q <= 1'b1;
          end
        prc_pkg::RX_DATA:
          if (grp_tick & grp == prc_pkg::CG_T)
            st_q <= prc_pkg::RX_WAIT_R;
          else if (grp_tick & grp == prc_pkg::CG_I)
            st_q <= prc_pkg::RX_HUNT;
        prc_pkg::RX_WAIT_R:
          if (grp_tick)
            st_q <= prc_pkg::RX_HUNT;
        default: st_q <= prc_pkg::RX_HUNT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 10M Manchester receive: bit is the second half, equal halves are errors
  assign ev10 = en & ~spd_q & lfall & cnt10_q == 2'h3;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      h1_q <= 1'b0;
      herr_q <= 1'b0;
      nib10_q <= 4'h0;
      cnt10_q <= 2'h0;
    end
    else if (~en | spd_q | ~lvl_n[2])
    begin
      cnt10_q <= 2'h0;
      herr_q <= 1'b0;
    end
    else if (lrise)
      h1_q <= dat;
    else if (lfall)
    begin
      nib10_q <= {dat, nib10_q[3:1]};
      cnt10_q <= cnt10_q + 2'h1;
      herr_q <= (cnt10_q != 2'h3) & (herr_q | (dat == h1_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // MII receive outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxd <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      rx_nib_stb <= 1'b0;
    end
    else
    begin
      rx_nib_stb <= 1'b0;
      rx_er <= 1'b0;
      if (~en)
      begin
        rx_dv <= 1'b0;
        rxd <= 4'h0;
      end
      else if (~spd_q)
      begin
        rx_dv <= lvl_n[2];
        if (ev10)
        begin
          rxd <= {dat, nib10_q[3:1]};
          rx_er <= herr_q | (dat == h1_q);
          rx_nib_stb <= 1'b1;
        end
      end
      else if (jk_hit | pre2_tick)
      begin
        rx_dv <= 1'b1;
        rxd <= prc_pkg::PRE_NIB;
        rx_nib_stb <= 1'b1;
      end
      else if (grp_tick & st_q == prc_pkg::RX_DATA)
      begin
        if (grp == prc_pkg::CG_I)
        begin
          rx_dv <= 1'b0;
          rx_er <= 1'b1;
        end
        else if (grp != prc_pkg::CG_T)
        begin
          rxd <= dec[3:0];
          rx_er <= dec[4];
          rx_nib_stb <= 1'b1;
        end
      end
      else if (grp_tick & st_q == prc_pkg::RX_WAIT_R)
      begin
        rx_dv <= 1'b0;
        rx_er <= grp != prc_pkg::CG_R;
      end
      else if (st_q == prc_pkg::RX_HUNT)
        rx_dv <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 10M Manchester transmit, LSB first, inverted half then true half
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_q <= 1'b0;
      ph_q <= 1'b0;
      sh_q <= 4'h0;
      hcnt_q <= 4'h0;
      bit_q <= 2'h0;
      tx_nib_req <= 1'b0;
      man_tx <= 1'b0;
    end
    else
    begin
      tx_nib_req <= 1'b0;
      man_tx <= busy_q & ~(ph_q ^ sh_q[0]);
      if (~en | spd_q)
        busy_q <= 1'b0;
      else if (~busy_q)
      begin
        if (tx_en)
        begin
          busy_q <= 1'b1;
          sh_q <= txd;
          tx_nib_req <= 1'b1;
          {ph_q, bit_q, hcnt_q} <= 7'h00;
        end
      end
      else if (hcnt_q != prc_pkg::TX_HALF_CYC - 4'h1)
        hcnt_q <= hcnt_q + 4'h1;
      else
      begin
        hcnt_q <= 4'h0;
        ph_q <= ~ph_q;
        if (ph_q)
        begin
          bit_q <= bit_q + 2'h1;
          sh_q <= {1'b0, sh_q[3:1]};
          if (bit_q == 2'h3)
          begin
            busy_q <= tx_en;
            sh_q <= txd;
            tx_nib_req <= tx_en;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Carrier sense and collision
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      crs <= 1'b0;
      col <= 1'b0;
    end
    else
    begin
      crs <= en & (rx_dv | (tx_en & ~fdx_q));
      col <= en & ~fdx_q & tx_en & rx_dv;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_jk;
    jk_hit;
  endsequence

  AST_COL_FDX: assert property (@(posedge hclk) disable iff (!hresetn)
    fdx_q |=> !col) else $error("collision in full duplex");
  AST_COL_HDX: assert property (@(posedge hclk) disable iff (!hresetn)
    en && !fdx_q && tx_en && rx_dv |=> col) else $error("missed collision");
  AST_CRS_FDX: assert property (@(posedge hclk) disable iff (!hresetn)
    fdx_q && !rx_dv |=> !crs) else $error("crs from own transmit");
  AST_CRS_HDX: assert property (@(posedge hclk) disable iff (!hresetn)
    en && !fdx_q && tx_en |=> crs) else $error("crs missing on transmit");
  AST_PDOWN: assert property (@(posedge hclk) disable iff (!hresetn)
    pdown [*2] |-> !rx_dv && !link_q && !busy_q) else $error("active in power down");
  AST_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q != prc_pkg::RX_HUNT |-> locked_q) else $error("aligned while unlocked");
  AST_JK_PRE: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_jk |=> rx_nib_stb && rxd == prc_pkg::PRE_NIB && rx_dv) else $error("no preamble");
  AST_T_STRIP: assert property (@(posedge hclk) disable iff (!hresetn)
    grp_tick && grp == prc_pkg::CG_T |=> !rx_nib_stb) else $error("T forwarded");
  AST_APR_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    !vend_q[prc_pkg::VEND_APR] |=> !pwr_red_q) else $error("reduced while disabled");
  AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    sig_any |=> !pwr_red_q ##1 !pwr_low) else $error("no wake on signal");
endmodule
`default_nettype wire

/* bench/prc_line_model.sv */
// Line partner model: scrambled NRZI 5B stream, clock runs only in bursts
`timescale 1ns/1ps
`default_nettype none
module prc_line_model (
  // Recovered line clock and data
  output logic line_clk,
  output logic line_dat
);
  logic [10:0] lfsr_q;
  logic nrzi_q;
  initial
  begin
    line_clk = 1'b0;
    line_dat = 1'b0;
    lfsr_q = 11'h5A5;
    nrzi_q = 1'b0;
  end
  // One bit: scramble, NRZI, then one 400 ns clock period
  task automatic send_bit(input logic b);
    logic s;
    begin
      s = lfsr_q[10] ^ lfsr_q[8];
      lfsr_q = {lfsr_q[9:0], s};
      nrzi_q = nrzi_q ^ b ^ s;
      // Nonblocking, so pins move after any clock edge in the same time step
      line_dat <= nrzi_q;
      #200 line_clk <= 1'b1;
      #200 line_clk <= 1'b0;
    end
  endtask
  // Group goes out with its top bit first
  task automatic send_group(input logic [4:0] g);
    for (int i = 4; i >= 0; i--)
      send_bit(g[i]);
  endtask
  // Idle run for lock, delimiters around four data groups
  task automatic send_frame(input logic [4:0] d0, d1, d2, d3);
    repeat (8) send_group(prc_pkg::CG_I);
    send_group(prc_pkg::CG_J);
    send_group(prc_pkg::CG_K);
    send_group(d0);
    send_group(d1);
    send_group(d2);
    send_group(d3);
    send_group(prc_pkg::CG_T);
    send_group(prc_pkg::CG_R);
    repeat (2) send_group(prc_pkg::CG_I);
    // Released line: no stale level left behind
    line_dat <= ~line_dat;
  endtask
endmodule
`default_nettype wire

/* bench/phy_receive_coding_and_link_control_tb_top.sv */
// Testbench for the PHY receive coding and link control block
`timescale 1ns/1ps
`default_nettype none
module phy_receive_coding_and_link_control_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic line_clk;
  logic line_dat;
  logic sig_detect = 1'b0;
  logic sig_flp = 1'b0;
  logic sig_nlp = 1'b0;
  logic sig_mlt3 = 1'b0;
  logic lp_word_stb = 1'b0;
  logic [3:0] lp_word = 4'h0;
  logic tx_en = 1'b0;
  logic [3:0] txd = 4'hA;
  logic [3:0] rxd;
  logic rx_dv, rx_er, rx_nib_stb, crs, col, flp_out, adv_ack, pwr_low, man_tx, tx_nib_req, link_up, hresp;
  logic [3:0] adv_word;
  logic [3:0] nibs[$];
  logic er_seen = 1'b0;
  logic col_seen = 1'b0;
  int flp_cnt = 0;
  int cyc = 0;
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] v;
  logic [7:0] man_sh;
  logic [3:0] exp_nib[6] = '{4'h5, 4'h5, 4'h0, 4'h1, 4'h2, 4'h3};
  ////////////////////////////////////////////////////////////////////////
  always #25 hclk = ~hclk;
  prc_line_model i_line (.line_clk(line_clk), .line_dat(line_dat));
  // Short idle timeout keeps the power tests brief
  prc_phy_rx #(.IDLE_CYC(50)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .line_clk(line_clk), .line_dat(line_dat), .sig_detect(sig_detect), .sig_flp(sig_flp),
    .sig_nlp(sig_nlp), .sig_mlt3(sig_mlt3), .lp_word_stb(lp_word_stb), .lp_word(lp_word),
    .tx_en(tx_en), .txd(txd), .tx_nib_req(tx_nib_req), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .rx_nib_stb(rx_nib_stb), .crs(crs), .col(col), .man_tx(man_tx), .flp_out(flp_out),
    .adv_word(adv_word), .adv_ack(adv_ack), .pwr_low(pwr_low), .link_up(link_up)
  );
  ////////////////////////////////////////////////////////////////////////
  // Monitor: nibble strobes, error and collision marks, link pulses
  always @(posedge hclk)
  begin
    if (rx_nib_stb === 1'b1)
      nibs.push_back(rxd);
    if (rx_er === 1'b1)
      er_seen <= 1'b1;
    if (col === 1'b1)
      col_seen <= 1'b1;
    if (flp_out === 1'b1)
      flp_cnt++;
    cyc++;
    // Whole run needs well under this many cycles
    if (cyc == 30000)
    begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // One single AHB-Lite word transfer, waits on hready each phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, v);
    chk(nm, exp, v);
  endtask
  task automatic test_done;
    $display("Counts: compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values and an unmapped word
    rdchk("ctrl", prc_pkg::REG_CTRL, {16'h0, prc_pkg::CTRL_RST});
    rdchk("vendor", prc_pkg::REG_VEND, {16'h0, prc_pkg::VEND_RST});
    rdchk("adv", prc_pkg::REG_ADV, {28'h0, prc_pkg::ADV_RST});
    rdchk("unmapped", 8'h20, 32'h0);
    $display("test registers done");
    // Forced 100M full duplex, frame with four data groups
    sig_detect <= 1'b1;
    sig_mlt3 <= 1'b1;
    wr(prc_pkg::REG_CTRL, 32'h2100);
    repeat (20) @(posedge hclk);
    i_line.send_frame(5'h1E, 5'h09, 5'h14, 5'h15);
    repeat (20) @(posedge hclk);
    chk("nibble count", 32'd6, nibs.size());
    for (int i = 0; i < 6 && i < nibs.size(); i++)
      chk("nibble", {28'h0, exp_nib[i]}, {28'h0, nibs[i]});
    chk("rx_dv after end", 32'h0, {31'h0, rx_dv});
    chk("clean frame error", 32'h0, {31'h0, er_seen});
    // Error group inside a frame
    i_line.send_frame(5'h1E, 5'h04, 5'h09, 5'h14);
    repeat (20) @(posedge hclk);
    chk("error group", 32'h1, {31'h0, er_seen});
    $display("test receive path done");
    // Carrier and collision in both duplex modes
    tx_en <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("crs full duplex", 32'h0, {31'h0, crs});
    i_line.send_frame(5'h1E, 5'h09, 5'h14, 5'h15);
    // Frame ends on an edge time step; resync so the bus task starts after an edge
    @(posedge hclk);
    chk("col full duplex", 32'h0, {31'h0, col_seen});
    wr(prc_pkg::REG_CTRL, 32'h2000);
    repeat (4) @(posedge hclk);
    chk("crs half duplex", 32'h1, {31'h0, crs});
    i_line.send_frame(5'h1E, 5'h09, 5'h14, 5'h15);
    @(posedge hclk);
    chk("col half duplex", 32'h1, {31'h0, col_seen});
    // Power down stops carrier while management stays reachable
    wr(prc_pkg::REG_CTRL, 32'h2800);
    repeat (4) @(posedge hclk);
    chk("crs power down", 32'h0, {31'h0, crs});
    bus(1'b0, prc_pkg::REG_STAT, 32'h0, v);
    chk("status power down", 32'h1, v & 32'h1);
    chk("okay in power down", 32'h0, {31'h0, hresp});
    tx_en <= 1'b0;
    $display("test carrier done");
    // Signal loss, link pulses, wake-up, then auto reduction off
    wr(prc_pkg::REG_CTRL, 32'h2000);
    sig_detect <= 1'b0;
    sig_mlt3 <= 1'b0;
    repeat (80) @(posedge hclk);
    chk("reduced power", 32'h1, {31'h0, pwr_low});
    flp_cnt = 0;
    repeat (400) @(posedge hclk);
    chk("pulses while reduced", 32'h1, {31'h0, flp_cnt > 0});
    sig_flp <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("wake on pulses", 32'h0, {31'h0, pwr_low});
    wr(prc_pkg::REG_VEND, 32'h0);
    sig_flp <= 1'b0;
    repeat (80) @(posedge hclk);
    chk("no auto reduction", 32'h0, {31'h0, pwr_low});
    $display("test power done");
    // Negotiation: ten megabit only advertised, partner offers all
    wr(prc_pkg::REG_ADV, 32'h3);
    wr(prc_pkg::REG_CTRL, 32'h1000);
    sig_detect <= 1'b1;
    sig_flp <= 1'b1;
    lp_word <= 4'hF;
    lp_word_stb <= 1'b1;
    @(posedge hclk);
    lp_word_stb <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("adv word", 32'h3, {28'h0, adv_word});
    chk("ack common", 32'h1, {31'h0, adv_ack});
    rdchk("partner", prc_pkg::REG_LPA, 32'hF);
    bus(1'b0, prc_pkg::REG_STAT, 32'h0, v);
    chk("resolved mode", 32'h8, v & 32'hC);
    chk("link up", 32'h1, {31'h0, link_up});
    $display("test negotiation done");
    // Resolved 10M: nibble 3 goes out LSB first, inverted half first, one cycle a half
    txd <= 4'h3;
    tx_en <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("nibble request", 32'h1, {31'h0, tx_nib_req});
    for (int i = 0; i < 8; i++)
    begin
      @(posedge hclk);
      man_sh = {man_sh[6:0], man_tx};
    end
    chk("manchester", 32'h5A, {24'h0, man_sh});
    tx_en <= 1'b0;
    $display("test 10M transmit done");
    // Parallel detection: partner without negotiation shows only line activity
    wr(prc_pkg::REG_ADV, 32'hF);
    wr(prc_pkg::REG_CTRL, 32'h0);
    wr(prc_pkg::REG_CTRL, 32'h1000);
    sig_mlt3 <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(1'b0, prc_pkg::REG_STAT, 32'h0, v);
    chk("parallel detect", 32'h6, v & 32'hE);
    $display("test parallel detect done");
    test_done();
  end
endmodule
`default_nettype wire
